// ===== core/mcx_regs.vh
// constants for the extended-resolution and pin/fan_speed_input configuration register pair
// assumes: included by bare name from the core/ design files, macros only
`ifndef MCX_REGS_VH
`define MCX_REGS_VH

// ==========================================================
// register offsets
`define MCX_OFS_EXT_LOW_TWO 8'h77
`define MCX_OFS_PIN_FAN_SPEED_INPUT_CFG 8'h78
`define MCX_OFS_UPPER_12V 8'h20
`define MCX_OFS_UPPER_REM1 8'h21
`define MCX_OFS_UPPER_LOCAL 8'h22
`define MCX_OFS_UPPER_REM2 8'h23

// ==========================================================
// reset values
`define MCX_RST_EXT_LOW_TWO 8'h00
`define MCX_RST_PIN_FAN_SPEED_INPUT_CFG 8'h00

// ==========================================================
// configuration field positions
`define MCX_BIT_ALERT_SEL 0
`define MCX_BIT_THERMAL_EVENT_PIN_EN 1
`define MCX_BIT_FAILSAFE_FULL_DRIVE 2
`define MCX_BIT_FAST 3
`define MCX_BIT_CONT_LO 4
`define MCX_BIT_CONT_HI 7

// ==========================================================
// multiuse pin select codes
`define MCX_SEL_FAN4 2'h0
`define MCX_SEL_THERMAL_EVENT_PIN 2'h1
`define MCX_SEL_ALERT 2'h2
`define MCX_SEL_GPIO 2'h3

// ==========================================================
// timing, in printed units, and the clock rate
`define MCX_CLK_KHZ 50000
`define MCX_CLK_MHZ 50
`define MCX_FAN_SPEED_INPUT_SLOW_MS 1000
`define MCX_FAN_SPEED_INPUT_FAST_MS 250
`define MCX_THERMAL_EVENT_PIN_RES_US 22760

`endif

// ===== core/mcx_freeze.v
// snapshot store for four 10-bit results with read-triggered freeze
// assumes: results and their strobe come from logic on clk_in
`timescale 1ns/10ps

module mcx_freeze (
	input wire clk_in, // system clock
	input wire reset_in, // synchronous reset, active high
	input wire sample_valid_in, // new results present this cycle
	input wire [39:0] result_in, // four 10-bit results, channel 0 lowest
	input wire ext_read_in, // low-bits register read this cycle
	input wire [3:0] upper_read_in, // upper-byte register read, per channel
	output wire [31:0] upper_out, // stored upper bytes, channel 0 lowest
	output wire [7:0] low_out, // packed low bits, channel 0 in [1:0]
	output wire [39:0] full_out, // joined 10-bit results
	output wire frozen_out // any upper byte still awaiting its read
);

	reg [3:0] pending;
	wire [3:0] next_pending;
	wire frozen;

	// the freeze covers every upper byte until each one is read
	assign frozen = |pending;
	assign frozen_out = frozen;

	// ==========================================================
	// per-channel snapshot
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_chan
			reg [9:0] shadow;

			// a fresh low-bits read restarts the freeze, so set beats clear
			assign next_pending[i] = ext_read_in ? 1'b1 : (upper_read_in[i] ? 1'b0 : pending[i]);

			always @(posedge clk_in) begin
				if (reset_in) begin
					shadow <= 10'h000;
					pending[i] <= 1'b0;
				end else begin
					pending[i] <= next_pending[i];
					// no update while frozen, so a split read never mixes two samples
					if (sample_valid_in && !frozen && !ext_read_in) begin
						shadow <= result_in[i*10 +: 10];
					end
				end
			end

			assign upper_out[i*8 +: 8] = shadow[9:2];
			assign low_out[i*2 +: 2] = shadow[1:0];
			// upper byte first, then its two low bits
			assign full_out[i*10 +: 10] = {shadow[9:2], shadow[1:0]};
		end
	endgenerate

endmodule // mcx_freeze

// ===== core/mcx_fan_speed_input_sched.v
// fan_speed_input measurement scheduler: one start pulse per measurement period
// assumes: fast_in is a register bit on clk_in
`timescale 1ns/10ps
`include "mcx_regs.vh"

module mcx_fan_speed_input_sched #(
	parameter [25:0] SLOW_CYCLES = `MCX_FAN_SPEED_INPUT_SLOW_MS * `MCX_CLK_KHZ, // cycles per slow period
	parameter [25:0] FAST_CYCLES = `MCX_FAN_SPEED_INPUT_FAST_MS * `MCX_CLK_KHZ // cycles per fast period
) (
	input wire clk_in, // system clock
	input wire reset_in, // synchronous reset, active high
	input wire fast_in, // select the short period
	output reg start_out // one-cycle measurement start
);

	reg [25:0] count;
	wire [25:0] period;
	wire wrap;

	assign period = fast_in ? FAST_CYCLES : SLOW_CYCLES;
	// >= so that a switch to fast mid-count wraps at once instead of running on
	assign wrap = (count >= (period - 26'h0000001));

	// ==========================================================
	// period counter
	always @(posedge clk_in) begin
		if (reset_in) begin
			count <= 26'h0000000;
			start_out <= 1'b0;
		end else begin
			start_out <= wrap;
			if (wrap) begin
				count <= 26'h0000000;
			end else begin
				count <= count + 26'h0000001;
			end
		end
	end

endmodule // mcx_fan_speed_input_sched

// ===== core/mcx_top.v
// extended-resolution low bits and pin/fan_speed_input configuration for the fan and thermal monitor
// assumes: the serial bus engine presents a one-cycle register read/write port on clk_in,
// the lock bit and the other configuration fields come from registers on clk_in,
// and pins 22 and 14 are asynchronous and active low when used as thermal inputs
`timescale 1ns/10ps
`include "mcx_regs.vh"

module mcx_top #(
	parameter [20:0] THERMAL_EVENT_PIN_TICK_CYCLES = `MCX_THERMAL_EVENT_PIN_RES_US * `MCX_CLK_MHZ, // cycles per timer step
	parameter [25:0] FAN_SPEED_INPUT_SLOW_CYCLES = `MCX_FAN_SPEED_INPUT_SLOW_MS * `MCX_CLK_KHZ, // slow fan_speed_input period
	parameter [25:0] FAN_SPEED_INPUT_FAST_CYCLES = `MCX_FAN_SPEED_INPUT_FAST_MS * `MCX_CLK_KHZ // fast fan_speed_input period
) (
	input wire clk_in, // 50 MHz system clock
	input wire reset_in, // synchronous reset, active high
	input wire [7:0] reg_addr_in, // register offset
	input wire reg_wr_in, // one-cycle write strobe
	input wire reg_rd_in, // one-cycle read strobe
	input wire [7:0] reg_wdata_in, // write data
	output reg [7:0] reg_rdata_out, // read data, one cycle after the strobe
	output reg reg_rvalid_out, // read data valid pulse
	input wire lock_in, // lock bit of configuration one
	input wire thermal_event_pin_bidir_in, // configuration five two-way bits set
	input wire [1:0] multiuse_pin_select_in, // pin 14 function code of configuration four
	input wire sample_valid_in, // new conversion results this cycle
	input wire [9:0] volt12_in, // 12 V result
	input wire [9:0] remote_one_in, // remote one temperature result
	input wire [9:0] local_in, // local temperature result
	input wire [9:0] remote_two_in, // remote two temperature result
	input wire alert_req_in, // unmasked out-of-limit condition present
	input wire fan_drive_two_in, // second fan drive waveform
	input wire overtemp_in, // device wants to assert the thermal pin
	input wire thermal_event_pin_in, // pin 22 level
	input wire pin14_in, // pin 14 level
	output reg pin10_out, // shared pin 10 output level
	output reg pin10_oe_out, // shared pin 10 drive enable
	output reg thermal_event_pin_out, // pin 22 output level
	output reg thermal_event_pin_oe_out, // pin 22 drive enable
	output reg pin14_out, // pin 14 output level
	output reg pin14_oe_out, // pin 14 drive enable
	output reg pin22_thermal_out, // pin 22 is the thermal pin, else 2.5 V input
	output reg [3:0] pin14_role_out, // one-hot: fan4 speed, thermal, alert, general io six
	output reg full_speed_out, // run all fans at full speed
	output reg failsafe_full_drive_out, // run all fans at highest programmed duty
	output reg [7:0] thermal_event_pin_time_out, // thermal assertion time in timer steps
	output reg thermal_event_pin_assert_out, // pulse on each new thermal assertion
	output reg fan_speed_input_start_out, // fan_speed_input measurement start pulse
	output reg [3:0] fan_speed_input_continuous_out, // per-channel continuous measurement
	output reg [3:0] stretch_enable_out, // per-channel pulse stretching allowed
	output reg [39:0] result_out, // four joined 10-bit results, 12 V lowest
	output reg frozen_out // upper bytes held awaiting reads
);

	// ==========================================================
	// pin 14 role decode, shared by the role output and the pin logic
	function [3:0] role_of;
		input [1:0] sel;
		begin
			case (sel)
				`MCX_SEL_FAN4: role_of = 4'h1;
				`MCX_SEL_THERMAL_EVENT_PIN: role_of = 4'h2;
				`MCX_SEL_ALERT: role_of = 4'h4;
				`MCX_SEL_GPIO: role_of = 4'h8;
				default: role_of = 4'h1;
			endcase
		end
	endfunction

	reg [7:0] cfg;
	reg [1:0] p22_sync;
	reg [1:0] p14_sync;
	reg thermal_event_pin_prev;
	reg [20:0] tick_cnt;
	wire [3:0] role14;
	wire p22_thermal;
	wire p14_thermal;
	wire thermal_event_pin_enabled;
	wire drive_thermal_event_pin;
	wire ext_assert;
	wire wr_cfg;
	wire rd_ext;
	wire [3:0] rd_upper;
	wire [31:0] upper;
	wire [7:0] low_bits;
	wire [39:0] full;
	wire frozen;
	wire fan_speed_input_pulse;
	wire step;

	// ==========================================================
	// register access decode
	assign wr_cfg = reg_wr_in && (reg_addr_in == `MCX_OFS_PIN_FAN_SPEED_INPUT_CFG) && !lock_in;
	assign rd_ext = reg_rd_in && (reg_addr_in == `MCX_OFS_EXT_LOW_TWO);
	assign rd_upper[0] = reg_rd_in && (reg_addr_in == `MCX_OFS_UPPER_12V);
	assign rd_upper[1] = reg_rd_in && (reg_addr_in == `MCX_OFS_UPPER_REM1);
	assign rd_upper[2] = reg_rd_in && (reg_addr_in == `MCX_OFS_UPPER_LOCAL);
	assign rd_upper[3] = reg_rd_in && (reg_addr_in == `MCX_OFS_UPPER_REM2);

	// configuration register; a locked write leaves it untouched
	always @(posedge clk_in) begin
		if (reset_in) begin
			cfg <= `MCX_RST_PIN_FAN_SPEED_INPUT_CFG;
		end else if (wr_cfg) begin
			cfg <= reg_wdata_in;
		end
	end

	// ==========================================================
	// snapshot store of the four results
	mcx_freeze u_freeze (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.sample_valid_in(sample_valid_in),
		.result_in({remote_two_in, local_in, remote_one_in, volt12_in}),
		.ext_read_in(rd_ext),
		.upper_read_in(rd_upper),
		.upper_out(upper),
		.low_out(low_bits),
		.full_out(full),
		.frozen_out(frozen)
	);

	// read mux; the snapshot is sampled in the strobe cycle, before the freeze lands
	always @(posedge clk_in) begin
		if (reset_in) begin
			reg_rdata_out <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in) begin
				case (reg_addr_in)
					`MCX_OFS_EXT_LOW_TWO: reg_rdata_out <= {low_bits[7:6], low_bits[5:4],
						low_bits[3:2], low_bits[1:0]};
					`MCX_OFS_PIN_FAN_SPEED_INPUT_CFG: reg_rdata_out <= cfg;
					`MCX_OFS_UPPER_12V: reg_rdata_out <= upper[7:0];
					`MCX_OFS_UPPER_REM1: reg_rdata_out <= upper[15:8];
					`MCX_OFS_UPPER_LOCAL: reg_rdata_out <= upper[23:16];
					`MCX_OFS_UPPER_REM2: reg_rdata_out <= upper[31:24];
					default: reg_rdata_out <= 8'h00;
				endcase
			end
		end
	end

	// ==========================================================
	// pin synchronisers; only the second stage is read
	always @(posedge clk_in) begin
		if (reset_in) begin
			p22_sync <= 2'h3;
			p14_sync <= 2'h3;
		end else begin
			p22_sync <= {p22_sync[0], thermal_event_pin_in};
			p14_sync <= {p14_sync[0], pin14_in};
		end
	end

	// ==========================================================
	// pin roles
	assign role14 = role_of(multiuse_pin_select_in);
	// pin 22 stays the 2.5 V input for code 01 even with thermal enabled
	assign p22_thermal = cfg[`MCX_BIT_THERMAL_EVENT_PIN_EN] && (multiuse_pin_select_in != `MCX_SEL_THERMAL_EVENT_PIN);
	assign p14_thermal = role14[1];
	assign thermal_event_pin_enabled = p22_thermal || p14_thermal;
	// device drives the thermal pin only in two-way mode
	assign drive_thermal_event_pin = thermal_event_pin_enabled && thermal_event_pin_bidir_in && overtemp_in;
	// external assertion seen only while the pin is an input, so our own drive never loops back
	assign ext_assert = !drive_thermal_event_pin && ((p22_thermal && !p22_sync[1]) || (p14_thermal && !p14_sync[1]));

	// pin drivers and role reporting
	always @(posedge clk_in) begin
		if (reset_in) begin
			pin10_out <= 1'b0;
			pin10_oe_out <= 1'b0;
			thermal_event_pin_out <= 1'b0;
			thermal_event_pin_oe_out <= 1'b0;
			pin14_out <= 1'b0;
			pin14_oe_out <= 1'b0;
			pin22_thermal_out <= 1'b0;
			pin14_role_out <= 4'h1;
		end else begin
			pin22_thermal_out <= p22_thermal;
			pin14_role_out <= role14;
			// alert is open drain, pulled low only while a condition is present
			if (cfg[`MCX_BIT_ALERT_SEL]) begin
				pin10_out <= 1'b0;
				pin10_oe_out <= alert_req_in;
			end else begin
				pin10_out <= fan_drive_two_in;
				pin10_oe_out <= 1'b1;
			end
			thermal_event_pin_out <= 1'b0;
			thermal_event_pin_oe_out <= p22_thermal && drive_thermal_event_pin;
			pin14_out <= 1'b0;
			pin14_oe_out <= (p14_thermal && drive_thermal_event_pin) || (role14[2] && alert_req_in);
		end
	end

	// ==========================================================
	// fan overrides
	always @(posedge clk_in) begin
		if (reset_in) begin
			full_speed_out <= 1'b0;
			failsafe_full_drive_out <= 1'b0;
		end else begin
			full_speed_out <= drive_thermal_event_pin;
			failsafe_full_drive_out <= ext_assert && cfg[`MCX_BIT_FAILSAFE_FULL_DRIVE];
		end
	end

	// ==========================================================
	// thermal assertion timer; steps saturate rather than wrap so a long event never reads short
	assign step = (tick_cnt == (THERMAL_EVENT_PIN_TICK_CYCLES - 21'h000001));

	always @(posedge clk_in) begin
		if (reset_in) begin
			thermal_event_pin_prev <= 1'b0;
			tick_cnt <= 21'h000000;
			thermal_event_pin_time_out <= 8'h00;
			thermal_event_pin_assert_out <= 1'b0;
		end else begin
			thermal_event_pin_prev <= ext_assert;
			thermal_event_pin_assert_out <= ext_assert && !thermal_event_pin_prev && thermal_event_pin_enabled;
			if (!thermal_event_pin_enabled || !ext_assert) begin
				tick_cnt <= 21'h000000;
				if (!thermal_event_pin_enabled) begin
					thermal_event_pin_time_out <= 8'h00;
				end
			end else if (!thermal_event_pin_prev) begin
				tick_cnt <= 21'h000000;
				thermal_event_pin_time_out <= 8'h00;
			end else if (step) begin
				tick_cnt <= 21'h000000;
				if (thermal_event_pin_time_out != 8'hFF) begin
					thermal_event_pin_time_out <= thermal_event_pin_time_out + 8'h01;
				end
			end else begin
				tick_cnt <= tick_cnt + 21'h000001;
			end
		end
	end

	// ==========================================================
	// fan_speed_input scheduling and per-channel modes
	mcx_fan_speed_input_sched #(
		.SLOW_CYCLES(FAN_SPEED_INPUT_SLOW_CYCLES),
		.FAST_CYCLES(FAN_SPEED_INPUT_FAST_CYCLES)
	) u_sched (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.fast_in(cfg[`MCX_BIT_FAST]),
		.start_out(fan_speed_input_pulse)
	);

	// continuous channels skip stretching; dc drive of fans 1 and 2 is the system's job
	always @(posedge clk_in) begin
		if (reset_in) begin
			fan_speed_input_start_out <= 1'b0;
			fan_speed_input_continuous_out <= 4'h0;
			stretch_enable_out <= 4'hF;
		end else begin
			fan_speed_input_start_out <= fan_speed_input_pulse;
			fan_speed_input_continuous_out <= cfg[`MCX_BIT_CONT_HI:`MCX_BIT_CONT_LO];
			stretch_enable_out <= ~cfg[`MCX_BIT_CONT_HI:`MCX_BIT_CONT_LO];
		end
	end

	// ==========================================================
	// joined results and freeze status
	always @(posedge clk_in) begin
		if (reset_in) begin
			result_out <= 40'h0000000000;
			frozen_out <= 1'b0;
		end else begin
			result_out <= full;
			frozen_out <= frozen;
		end
	end

endmodule // mcx_top

// ===== tb/mcx_sensor_model.sv
// sensor and pin model for the far side of mcx_top
// assumes: results are requested by the bench, pins 22 and 14 have pull-ups
`timescale 1ns/10ps

module mcx_sensor_model (
	input wire clk_in, // system clock
	input wire convert_in, // conversion request
	input wire [39:0] vals_in, // results to deliver
	input wire dc_in, // fan two measured continuously
	input wire pull22_in, // outside party pulls pin 22 low
	input wire oe22_in, // device drives pin 22
	input wire lvl22_in, // device level on pin 22
	input wire oe14_in, // device drives pin 14
	input wire lvl14_in, // device level on pin 14
	output reg sample_valid_out, // results present this cycle
	output reg [39:0] results_out, // latest results, held
	output reg fan_drive_out, // second fan drive waveform
	output wire line22_out, // resolved pin 22 level
	output wire line14_out // resolved pin 14 level
);
	initial begin
		sample_valid_out = 1'b0;
		results_out = 40'h0;
		fan_drive_out = 1'b0;
	end
	// results land with their strobe; a dc driven fan gets a steady level
	always @(posedge clk_in) begin
		sample_valid_out <= convert_in;
		if (convert_in) begin
			results_out <= vals_in;
		end
		fan_drive_out <= dc_in ? 1'b1 : ~fan_drive_out;
	end
	// open drain wires: any low driver wins over the pull-up
	assign line22_out = !(pull22_in || (oe22_in && !lvl22_in));
	assign line14_out = !(oe14_in && !lvl14_in);
endmodule // mcx_sensor_model

// ===== tb/mcx_top_monitor.sv
// checker for the low-bits register and pin/fan_speed_input configuration
// assumes: bound to mcx_top, fan_speed_input periods handed on by the bind
`timescale 1ns/10ps

module mcx_top_monitor #(
	parameter [25:0] FAN_SPEED_INPUT_SLOW_CYCLES = 26'd40, // slow fan_speed_input period
	parameter [25:0] FAN_SPEED_INPUT_FAST_CYCLES = 26'd10 // fast fan_speed_input period
) (
	input wire clk_in, // system clock
	input wire reset_in, // synchronous reset
	input wire [7:0] reg_addr_in, // register offset
	input wire reg_rd_in, // read strobe
	input wire [7:0] reg_rdata_out, // read data
	input wire reg_rvalid_out, // read valid
	input wire thermal_event_pin_bidir_in, // two-way thermal pin
	input wire overtemp_in, // device wants the pin
	input wire fan_drive_two_in, // fan drive waveform
	input wire pin10_out, // shared pin level
	input wire pin10_oe_out, // shared pin enable
	input wire thermal_event_pin_out, // pin 22 level
	input wire thermal_event_pin_oe_out, // pin 22 enable
	input wire pin14_out, // pin 14 level
	input wire pin22_thermal_out, // pin 22 role
	input wire [3:0] pin14_role_out, // pin 14 role
	input wire full_speed_out, // full speed
	input wire failsafe_full_drive_out, // failsafe_full_drive drive
	input wire fan_speed_input_start_out, // fan_speed_input start
	input wire [3:0] fan_speed_input_continuous_out, // continuous
	input wire [3:0] stretch_enable_out, // stretching
	input wire [39:0] result_out, // joined results
	input wire frozen_out // freeze held
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	reg [25:0] gap;
	reg seen;
	// cycles since the last fan_speed_input start; the first pulse after reset has no reference
	always @(posedge clk_in) begin
		if (reset_in) begin
			gap <= 26'd0;
			seen <= 1'b0;
		end else if (fan_speed_input_start_out) begin
			gap <= 26'd0;
			seen <= 1'b1;
		end else begin
			gap <= gap + 26'd1;
		end
	end
	a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out) else $error("read without answer");
	a_valid_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in)) else $error("stray read valid");
	a_low_pack: assert property (reg_rvalid_out && $past(reg_addr_in) == 8'h77 |-> reg_rdata_out ==
		{result_out[31:30], result_out[21:20], result_out[11:10], result_out[1:0]})
		else $error("low bits misplaced");
	a_freeze_hold: assert property (frozen_out && $past(frozen_out) |-> $stable(result_out))
		else $error("result moved while frozen");
	a_alert_or_drive: assert property (pin10_out |-> pin10_oe_out && $past(fan_drive_two_in))
		else $error("shared pin level wrong");
	a_open_drain: assert property (!thermal_event_pin_out && !pin14_out) else $error("pin driven high");
	a_full_speed: assert property ((full_speed_out |-> $past(overtemp_in) && $past(thermal_event_pin_bidir_in))
		and (thermal_event_pin_oe_out |-> full_speed_out)) else $error("full speed without cause");
	a_role_onehot: assert property ($onehot(pin14_role_out) && !(pin22_thermal_out && pin14_role_out == 4'h2))
		else $error("pin roles wrong");
	a_fan_speed_input_gap: assert property (fan_speed_input_start_out && seen |-> gap >= FAN_SPEED_INPUT_FAST_CYCLES - 26'd1 &&
		gap <= FAN_SPEED_INPUT_SLOW_CYCLES - 26'd1) else $error("fan_speed_input period wrong");
	a_cont_stretch: assert property (fan_speed_input_continuous_out == ~stretch_enable_out)
		else $error("stretch not opposite");
	c_fan_speed_input: cover property (fan_speed_input_start_out);
	c_freeze: cover property ($rose(frozen_out));
	c_failsafe_full_drive: cover property (failsafe_full_drive_out);
	c_full: cover property (full_speed_out);
endmodule // mcx_top_monitor

bind mcx_top mcx_top_monitor #(.FAN_SPEED_INPUT_SLOW_CYCLES(FAN_SPEED_INPUT_SLOW_CYCLES), .FAN_SPEED_INPUT_FAST_CYCLES(FAN_SPEED_INPUT_FAST_CYCLES)) mon (
	.clk_in, .reset_in, .reg_addr_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .thermal_event_pin_bidir_in,
	.overtemp_in, .fan_drive_two_in, .pin10_out, .pin10_oe_out, .thermal_event_pin_out,
	.thermal_event_pin_oe_out, .pin14_out, .pin22_thermal_out, .pin14_role_out, .full_speed_out,
	.failsafe_full_drive_out, .fan_speed_input_start_out, .fan_speed_input_continuous_out, .stretch_enable_out,
	.result_out, .frozen_out);

// ===== tb/mcx_top_tb_top.sv
// bench for mcx_top: register access, freeze, pin roles, thermal and fan_speed_input
// assumes: sensor model beside the design, checker bound in its own file
`timescale 1ns/10ps

module mcx_top_tb_top;
	reg clk_in = 1'b0;
	reg reset_in = 1'b1;
	reg [7:0] reg_addr_in = 8'h00;
	reg reg_wr_in = 1'b0;
	reg reg_rd_in = 1'b0;
	reg [7:0] reg_wdata_in = 8'h00;
	reg lock_in = 1'b0;
	reg thermal_event_pin_bidir_in = 1'b0;
	reg [1:0] sel = 2'h0;
	reg alert_req_in = 1'b0;
	reg overtemp_in = 1'b0;
	reg convert = 1'b0;
	reg [39:0] vals = 40'h0;
	reg pull22 = 1'b0;
	integer miscompares = 0;
	integer compares = 0;
	wire [7:0] reg_rdata_out, thermal_event_pin_time_out;
	wire [3:0] pin14_role_out, fan_speed_input_continuous_out, stretch_enable_out;
	wire [39:0] result_out, res;
	wire reg_rvalid_out, pin10_out, pin10_oe_out, thermal_event_pin_out, thermal_event_pin_oe_out;
	wire pin14_out, pin14_oe_out, pin22_thermal_out, full_speed_out, failsafe_full_drive_out;
	wire fan_speed_input_start_out, frozen_out, sv, fan2, line22, line14;
	// 50 MHz clock
	always #10 clk_in = ~clk_in;
	mcx_top #(.THERMAL_EVENT_PIN_TICK_CYCLES(21'd8), .FAN_SPEED_INPUT_SLOW_CYCLES(26'd40), .FAN_SPEED_INPUT_FAST_CYCLES(26'd10)) uut (
		.clk_in, .reset_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
		.reg_rvalid_out, .lock_in, .thermal_event_pin_bidir_in, .multiuse_pin_select_in(sel), .sample_valid_in(sv),
		.volt12_in(res[9:0]), .remote_one_in(res[19:10]), .local_in(res[29:20]), .remote_two_in(res[39:30]),
		.alert_req_in, .fan_drive_two_in(fan2), .overtemp_in, .thermal_event_pin_in(line22),
		.pin14_in(line14), .pin10_out, .pin10_oe_out, .thermal_event_pin_out, .thermal_event_pin_oe_out,
		.pin14_out, .pin14_oe_out, .pin22_thermal_out, .pin14_role_out, .full_speed_out,
		.failsafe_full_drive_out, .thermal_event_pin_time_out, .thermal_event_pin_assert_out(), .fan_speed_input_start_out,
		.fan_speed_input_continuous_out, .stretch_enable_out, .result_out, .frozen_out);
	mcx_sensor_model model (.clk_in, .convert_in(convert), .vals_in(vals), .dc_in(fan_speed_input_continuous_out[1]),
		.pull22_in(pull22), .oe22_in(thermal_event_pin_oe_out), .lvl22_in(thermal_event_pin_out),
		.oe14_in(pin14_oe_out), .lvl14_in(pin14_out), .sample_valid_out(sv), .results_out(res),
		.fan_drive_out(fan2), .line22_out(line22), .line14_out(line14));
	// ==========================================================
	// shared tasks
	task test_done;
	begin
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	end
	endtask
	task expire;
	begin
		miscompares = miscompares + 1;
		test_done;
	end
	endtask
	task cmp8(input [79:0] nm, input [7:0] e, input [7:0] g);
	begin
		compares = compares + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("unexpected %0s exp %h got %h", nm, e, g);
		end
	end
	endtask
	// strobes are raised and dropped at falling edges, one cycle wide
	task wr(input [7:0] a, input [7:0] d);
	begin
		@(negedge clk_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(negedge clk_in);
		reg_wr_in = 1'b0;
	end
	endtask
	task rdc(input [7:0] a, input [7:0] e);
	begin
		@(negedge clk_in);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		@(negedge clk_in);
		reg_rd_in = 1'b0;
		cmp8("rvalid", 8'h01, {7'h0, reg_rvalid_out});
		cmp8("rdata", e, reg_rdata_out);
	end
	endtask
	task conv(input [39:0] v);
	begin
		@(negedge clk_in);
		vals = v;
		convert = 1'b1;
		@(negedge clk_in);
		convert = 1'b0;
		repeat (2) @(negedge clk_in);
	end
	endtask
	function [7:0] lowp(input [39:0] v);
		lowp = {v[31:30], v[21:20], v[11:10], v[1:0]};
	endfunction
	task rd_up(input [39:0] v);
	reg [7:0] i;
	begin
		for (i = 8'h00; i < 8'h04; i = i + 8'h01) begin
			rdc(8'h20 + i, v[i * 10 + 2 +: 8]);
		end
	end
	endtask
	// ==========================================================
	// scenarios
	task t_freeze;
	reg [39:0] a;
	begin
		a = {10'h3C6, 10'h1B9, 10'h2E4, 10'h0A7};
		conv(a);
		rdc(8'h77, lowp(a));
		conv(~a);
		rd_up(a);
		cmp8("joined", 8'h01, {7'h0, result_out == a});
		repeat (4) @(negedge clk_in);
		conv(~a);
		rdc(8'h77, lowp(~a));
		rd_up(~a);
	end
	endtask
	task t_cfg;
	reg [3:0] k;
	begin
		for (k = 4'h0; k < 4'h8; k = k + 4'h1) begin
			sel = k[1:0];
			wr(8'h78, {6'h00, k[2], 1'b0});
			repeat (3) @(negedge clk_in);
			cmp8("role", 8'h01 << k[1:0], {4'h0, pin14_role_out});
			cmp8("pin22", {7'h0, k[2] && k[1:0] != 2'h1}, {7'h0, pin22_thermal_out});
		end
		sel = 2'h2;
		wr(8'h78, 8'h01);
		alert_req_in = 1'b1;
		repeat (3) @(negedge clk_in);
		// open drain alert: driven low while the condition stands
		cmp8("alert", 8'h02, {6'h0, pin10_oe_out, pin10_out});
		cmp8("pin14 oe", 8'h01, {7'h0, pin14_oe_out});
		alert_req_in = 1'b0;
		sel = 2'h0;
		wr(8'h78, 8'hA0);
		rdc(8'h78, 8'hA0);
		cmp8("cont", 8'h0A, {4'h0, fan_speed_input_continuous_out});
		cmp8("stretch", 8'h05, {4'h0, stretch_enable_out});
		cmp8("pwm oe", 8'h01, {7'h0, pin10_oe_out});
		lock_in = 1'b1;
		wr(8'h78, 8'h5F);
		rdc(8'h78, 8'hA0);
		lock_in = 1'b0;
		wr(8'h78, 8'h50);
		rdc(8'h78, 8'h50);
		cmp8("cont", 8'h05, {4'h0, fan_speed_input_continuous_out});
	end
	endtask
	task t_thermal_event_pin;
	integer n;
	begin
		wr(8'h78, 8'h06);
		pull22 = 1'b1;
		n = 0;
		while (failsafe_full_drive_out !== 1'b1 && n < 20) begin
			@(negedge clk_in);
			n = n + 1;
		end
		if (n >= 20) expire;
		repeat (30) @(negedge clk_in);
		cmp8("timer", 8'h01, {7'h0, thermal_event_pin_time_out >= 8'h03 && thermal_event_pin_time_out <= 8'h04});
		wr(8'h78, 8'h02);
		repeat (4) @(negedge clk_in);
		cmp8("failsafe_full_drive off", 8'h00, {7'h0, failsafe_full_drive_out});
		pull22 = 1'b0;
		thermal_event_pin_bidir_in = 1'b1;
		overtemp_in = 1'b1;
		repeat (5) @(negedge clk_in);
		cmp8("full", 8'h01, {7'h0, full_speed_out});
		cmp8("pin22 low", 8'h00, {7'h0, line22});
		thermal_event_pin_bidir_in = 1'b0;
		repeat (4) @(negedge clk_in);
		cmp8("in only", 8'h00, {6'h0, full_speed_out, thermal_event_pin_oe_out});
		overtemp_in = 1'b0;
	end
	endtask
	// the gap between the second and third start pulses avoids the partial first period
	task t_fan_speed_input(input [7:0] c, input [7:0] p);
	integer n, g, k;
	begin
		wr(8'h78, c);
		n = 0;
		g = 0;
		k = 0;
		while (k < 3 && n < 200) begin
			@(negedge clk_in);
			n = n + 1;
			g = g + 1;
			if (fan_speed_input_start_out === 1'b1) begin
				k = k + 1;
				if (k < 3) g = 0;
			end
		end
		if (k < 3) expire;
		cmp8("fan_speed_input gap", p, g[7:0]);
	end
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (12) @(negedge clk_in);
		reset_in = 1'b0;
		rdc(8'h77, 8'h00);
		// the low-bits read froze the snapshot; read every upper byte to release it
		rd_up(40'h0);
		rdc(8'h78, 8'h00);
		rdc(8'h55, 8'h00);
		cmp8("stretch", 8'h0F, {4'h0, stretch_enable_out});
		t_freeze;
		t_cfg;
		t_thermal_event_pin;
		t_fan_speed_input(8'h00, 8'd40);
		t_fan_speed_input(8'h08, 8'd10);
		test_done;
	end
endmodule // mcx_top_tb_top
